/* rtl/wbc_ctrl_regs.sv */
// wbc_ctrl_regs: watchdog and bus control registers behind a 16-bit spi
// assumes chip_mode, restart, soft_reset and hardware loads come from
// logic on clk; the spi pins belong to the host's own serial clock
`timescale 1ns/100ps
`default_nettype none
module wbc_ctrl_regs (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // chip level events, one clk cycle each
  input wire logic soft_reset,
  input wire logic restart,
  // chip operating mode
  input wire wbc_pkg::wbc_chip_mode_type chip_mode,
  // spi pins
  input wire logic spi_sck,
  input wire logic spi_cs_n,
  input wire logic spi_mosi,
  output logic spi_miso,
  output logic spi_miso_oe,
  // hardware updates of the hardware-owned bits
  input wire logic hw_wdog_load,
  input wire logic [7:0] hw_wdog_value,
  input wire logic hw_bus1_load,
  input wire logic [7:0] hw_bus1_value,
  input wire logic hw_bus2_load,
  input wire logic [7:0] hw_bus2_value,
  // spi failure flag and its clear from the status register
  input wire logic spi_fail_clear,
  output logic spi_fail,
  // boost default voltage selection in force
  input wire logic boost_default_sel,
  // register contents
  output logic [7:0] watchdog_control,
  output logic [7:0] bus_control_one,
  output logic [7:0] bus_control_two,
  // watchdog settings
  output logic wdog_stop_disable,
  output logic wdog_window_select,
  output logic wdog_start_on_bus_wake,
  output logic wdog_reset_limit,
  output logic [2:0] wdog_period_sel,
  output logic [9:0] wdog_period_ms,
  output logic wdog_active,
  // lin settings
  output logic lin_flash_mode,
  output logic lin_slope_ctrl_on,
  output logic lin_slow_slope_sel,
  output logic lin_tx_timeout_enable,
  // transceiver modes as operated, fields 1 to 4
  output logic [1:0] can_mode_op,
  output logic [3:0][1:0] lin_mode_op,
  // boost
  output logic boost_high_level_sel,
  output logic boost_target_10v
);
  import wbc_pkg::*;

  typedef struct packed {
    logic tog_meta;
    logic tog_sync;
    logic tog_seen;
    logic [7:0] wdog;
    logic [7:0] bus1;
    logic [7:0] bus2;
    logic [7:0] reply;
    logic fail;
    logic [1:0] can_op;
    logic [3:0][1:0] lin_op;
    logic [9:0] period_ms;
    logic wd_active;
    logic boost_10v;
  } wbc_core_type;

  wbc_core_type s_q;
  wbc_core_type s_d;
  wbc_link_if lnk ();

  // keeps old bits outside the mask
  function automatic logic [7:0] wbc_merge(
    input logic [7:0] old_val,
    input logic [7:0] new_val,
    input logic [7:0] mask
  );
    wbc_merge = (old_val & ~mask) | (new_val & mask);
  endfunction : wbc_merge

  // normal mode drops to wake capable while the chip sleeps or stops
  function automatic logic [1:0] wbc_op_mode(
    input logic [1:0] field,
    input logic low_power
  );
    if (low_power && field == WBC_TRX_NORMAL) begin
      wbc_op_mode = WBC_TRX_WAKE;
    end else begin
      wbc_op_mode = field;
    end
  endfunction : wbc_op_mode

  // period lookup; only legal codes are ever stored
  function automatic logic [9:0] wbc_period_of(input logic [2:0] code);
    if (code <= WBC_WD_CODE_LAST) begin
      wbc_period_of = WBC_WD_PERIOD_MS[code];
    end else begin
      wbc_period_of = WBC_WD_PERIOD_MS[WBC_WD_CODE_RESTART];
    end
  endfunction : wbc_period_of

  // serial side on the host's clock
  wbc_spi_link u_link (
    .spi_sck(spi_sck),
    .spi_cs_n(spi_cs_n),
    .spi_mosi(spi_mosi),
    .spi_miso(spi_miso),
    .reset(reset),
    .lnk(lnk.link)
  );

  logic frame_evt;
  logic frame_write;
  logic [6:0] frame_addr;
  logic [7:0] frame_data;
  logic parity_odd;
  logic fail_set;
  logic low_power;
  logic [7:0] wd_wr;

  // frame fields; the word has settled by the time its toggle is synced
  assign frame_evt = s_q.tog_sync ^ s_q.tog_seen;
  assign frame_addr = lnk.frame_word[6:0];
  assign frame_write = lnk.frame_word[WBC_WRITE_BIT];
  assign frame_data = lnk.frame_word[15:WBC_DATA_LSB];
  assign parity_odd = ^frame_data;
  assign low_power = (chip_mode == WBC_CHIP_STOP) ||
                     (chip_mode == WBC_CHIP_SLEEP);

  // a refused period code leaves the stored period as it was
  always_comb begin
    wd_wr = frame_data;
    if (frame_data[2:0] > WBC_WD_CODE_LAST) begin
      wd_wr[2:0] = s_q.wdog[2:0];
    end
  end

  // next state: resets first, then host write, then hardware update
  always_comb begin
    s_d = s_q;
    fail_set = 1'b0;
    // toggle crossing: meta flop is read by the sync flop only
    s_d.tog_meta = lnk.frame_toggle;
    s_d.tog_sync = s_q.tog_meta;
    s_d.tog_seen = s_q.tog_sync;
    if (soft_reset) begin
      s_d.wdog = WBC_WD_RESET;
      s_d.bus1 = WBC_B1_RESET;
      s_d.bus2 = WBC_B2_RESET;
    end else if (restart) begin
      s_d.wdog = (s_q.wdog & WBC_WD_KEEP_MASK) |
                 {5'h00, WBC_WD_CODE_RESTART};
      s_d.bus2 = s_q.bus2 & WBC_B2_KEEP_MASK;
    end else begin
      // host write decode
      if (frame_evt && frame_write) begin
        unique case (frame_addr)
          WBC_ADDR_WDOG: begin
            if (parity_odd) begin
              fail_set = 1'b1;
            end else begin
              s_d.wdog = wd_wr;
            end
          end
          WBC_ADDR_BUS1: begin
            s_d.bus1 = wbc_merge(s_q.bus1, frame_data, WBC_BUS_WR_MASK);
          end
          WBC_ADDR_BUS2: begin
            s_d.bus2 = wbc_merge(s_q.bus2, frame_data, WBC_BUS_WR_MASK);
          end
          default: begin
            s_d.wdog = s_q.wdog;
          end
        endcase
      end
      // hardware may only touch its own bits, and it has the last word
      if (hw_wdog_load) begin
        s_d.wdog = wbc_merge(s_d.wdog, hw_wdog_value, WBC_WD_HW_MASK);
        if (hw_wdog_value[2:0] > WBC_WD_CODE_LAST) begin
          s_d.wdog[2:0] = s_q.wdog[2:0];
        end
      end
      if (hw_bus1_load) begin
        s_d.bus1 = wbc_merge(s_d.bus1, hw_bus1_value, WBC_B1_HW_MASK);
      end
      if (hw_bus2_load) begin
        s_d.bus2 = wbc_merge(s_d.bus2, hw_bus2_value, WBC_B2_HW_MASK);
      end
    end
    // sticky failure flag: a new failure beats a clear in the same cycle
    s_d.fail = (s_q.fail & ~spi_fail_clear) | fail_set;
    // reply for the next frame shows the addressed register after update
    if (frame_evt) begin
      unique case (frame_addr)
        WBC_ADDR_WDOG: s_d.reply = s_d.wdog;
        WBC_ADDR_BUS1: s_d.reply = s_d.bus1;
        WBC_ADDR_BUS2: s_d.reply = s_d.bus2;
        default: s_d.reply = 8'h00;
      endcase
    end
    // operated transceiver modes; stored fields never change here
    s_d.can_op = wbc_op_mode(s_d.bus1[WBC_B1_CAN_LSB +: 2], low_power);
    s_d.lin_op[0] = wbc_op_mode(s_d.bus1[WBC_B1_LIN_FIRST_MODE_LSB +: 2], low_power);
    s_d.lin_op[1] = wbc_op_mode(s_d.bus2[WBC_B2_LIN2_LSB +: 2], low_power);
    s_d.lin_op[2] = wbc_op_mode(s_d.bus2[WBC_B2_LIN_THIRD_MODE_LSB +: 2], low_power);
    s_d.lin_op[3] = wbc_op_mode(s_d.bus2[WBC_B2_LIN_FOURTH_MODE_LSB +: 2], low_power);
    // watchdog timing and stop behaviour
    s_d.period_ms = wbc_period_of(s_d.wdog[WBC_WD_PERIOD_LSB +: 3]);
    s_d.wd_active = !((chip_mode == WBC_CHIP_STOP) &&
                      s_d.wdog[WBC_WD_STOP_DIS_BIT]);
    s_d.boost_10v = boost_default_sel && s_d.bus2[WBC_B2_BOOST_BIT];
  end

  // single state register; reset is synchronous
  always_ff @(posedge clk) begin
    if (reset) begin
      s_q <= '0;
      s_q.wdog <= WBC_WD_RESET;
      s_q.bus1 <= WBC_B1_RESET;
      s_q.bus2 <= WBC_B2_RESET;
      s_q.can_op <= WBC_B1_RESET[WBC_B1_CAN_LSB +: 2];
      s_q.period_ms <= WBC_WD_PERIOD_MS[WBC_WD_CODE_RESTART];
      s_q.wd_active <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // reply byte to the link; changes only just after a frame arrives
  assign lnk.reply_byte = s_q.reply;
  // pin is driven only inside a frame
  assign spi_miso_oe = ~spi_cs_n;

  // register contents
  assign spi_fail = s_q.fail;
  assign watchdog_control = s_q.wdog;
  assign bus_control_one = s_q.bus1;
  assign bus_control_two = s_q.bus2;

  // watchdog field outputs
  assign wdog_stop_disable = s_q.wdog[WBC_WD_STOP_DIS_BIT];
  assign wdog_window_select = s_q.wdog[WBC_WDOG_WINDOW_SELECT_BIT];
  assign wdog_start_on_bus_wake = s_q.wdog[WBC_WD_WAKE_BIT];
  assign wdog_reset_limit = s_q.wdog[WBC_WD_MAX3_BIT];
  assign wdog_period_sel = s_q.wdog[WBC_WD_PERIOD_LSB +: 3];
  assign wdog_period_ms = s_q.period_ms;
  assign wdog_active = s_q.wd_active;

  // lin field outputs
  assign lin_flash_mode = s_q.bus1[WBC_B1_FLASH_BIT];
  assign lin_slope_ctrl_on = ~s_q.bus1[WBC_B1_FLASH_BIT];
  assign lin_slow_slope_sel = s_q.bus1[WBC_B1_SLOW_BIT];
  assign lin_tx_timeout_enable = s_q.bus1[WBC_B1_TXTO_BIT];

  // operated modes and boost
  assign can_mode_op = s_q.can_op;
  assign lin_mode_op = s_q.lin_op;
  assign boost_high_level_sel = s_q.bus2[WBC_B2_BOOST_BIT];
  assign boost_target_10v = s_q.boost_10v;
endmodule : wbc_ctrl_regs
`default_nettype wire

/* include/wbc_pkg.sv */
// wbc_pkg: constants and types for the watchdog and bus control registers
// assumes 16-bit frames sent lsb first: address 6:0, write flag 7, data 15:8
//
// What this block does
// - watchdog_control writes need even parity over all bits; odd ones dropped
// - watchdog_control bit 6 switches the watchdog off in stop; hardware may set
// - watchdog_control bit 5 picks window watchdog instead of plain timeout
// - watchdog_control bit 4 starts the watchdog after a bus wake in stop
// - watchdog_control bit 3 stops resets after three consecutive watchdog resets
// - watchdog_control bits 2:0 pick 10 to 500 ms; codes 110 and 111 reserved
// - restart clears bits 6 and 5, loads period code 100, keeps the rest
// - bus_control_one bit 7 turns lin slope control off for flashing
// - bus_control_one bit 6 selects lin low slope
// - bus_control_one bit 5 enables the lin transmit timeout
// - bus_control_one bits 4:3 hold the first lin mode; hardware may update
// - bus_control_one bits 1:0 hold the can mode; hardware may update
// - stored can normal mode runs as wake capable in stop or sleep
// - stored lin normal mode runs as wake capable in stop or sleep
// - bit 2 of both bus registers reads zero and ignores writes
// - bus_control_two bits 7:6 and 4:3 hold fourth and third lin modes
// - bus_control_two bit 5 picks 10 V boost over 8 V under default selection
// - restart clears the boost bit of bus_control_two and keeps lin modes
// - frames are 16 bits: address, write flag, one data byte
package wbc_pkg;
  // register addresses
  localparam logic [6:0] WBC_ADDR_WDOG = 7'h03;
  localparam logic [6:0] WBC_ADDR_BUS1 = 7'h04;
  localparam logic [6:0] WBC_ADDR_BUS2 = 7'h05;
  // frame layout
  localparam int WBC_FRAME_BITS = 16;
  localparam int WBC_WRITE_BIT = 7;
  localparam int WBC_DATA_LSB = 8;
  // watchdog_control fields
  localparam int WBC_WD_STOP_DIS_BIT = 6;
  localparam int WBC_WDOG_WINDOW_SELECT_BIT = 5;
  localparam int WBC_WD_WAKE_BIT = 4;
  localparam int WBC_WD_MAX3_BIT = 3;
  localparam int WBC_WD_PERIOD_LSB = 0;
  localparam logic [2:0] WBC_WD_CODE_LAST = 3'h5;
  localparam logic [2:0] WBC_WD_CODE_RESTART = 3'h4;
  localparam logic [5:0][9:0] WBC_WD_PERIOD_MS =
    {10'h1F4, 10'h0C8, 10'h064, 10'h032, 10'h014, 10'h00A};
  // bus_control_one fields
  localparam int WBC_B1_FLASH_BIT = 7;
  localparam int WBC_B1_SLOW_BIT = 6;
  localparam int WBC_B1_TXTO_BIT = 5;
  localparam int WBC_B1_LIN_FIRST_MODE_LSB = 3;
  localparam int WBC_B1_CAN_LSB = 0;
  // bus_control_two fields
  localparam int WBC_B2_LIN_FOURTH_MODE_LSB = 6;
  localparam int WBC_B2_BOOST_BIT = 5;
  localparam int WBC_B2_LIN_THIRD_MODE_LSB = 3;
  localparam int WBC_B2_LIN2_LSB = 0;
  // reset values, writable bits, hardware bits, bits kept on restart
  localparam logic [7:0] WBC_WD_RESET = 8'h14;
  localparam logic [7:0] WBC_B1_RESET = 8'h20;
  localparam logic [7:0] WBC_B2_RESET = 8'h00;
  localparam logic [7:0] WBC_WD_HW_MASK = 8'h57;
  localparam logic [7:0] WBC_BUS_WR_MASK = 8'hFB;
  localparam logic [7:0] WBC_B1_HW_MASK = 8'h1B;
  localparam logic [7:0] WBC_B2_HW_MASK = 8'hDB;
  localparam logic [7:0] WBC_WD_KEEP_MASK = 8'h98;
  localparam logic [7:0] WBC_B2_KEEP_MASK = 8'hDB;
  // transceiver mode codes
  localparam logic [1:0] WBC_TRX_WAKE = 2'h1;
  localparam logic [1:0] WBC_TRX_NORMAL = 2'h3;
  // chip operating mode, driven by the mode controller
  typedef enum logic [1:0] {
    WBC_CHIP_NORMAL = 2'h0,
    WBC_CHIP_SLEEP = 2'h1,
    WBC_CHIP_STOP = 2'h2,
    WBC_CHIP_RESET = 2'h3
  } wbc_chip_mode_type;
endpackage : wbc_pkg

/* include/wbc_link_if.sv */
// wbc_link_if: words passed between the spi link logic and the register core
// assumes frame_word is stable whenever frame_toggle has crossed
`timescale 1ns/100ps
`default_nettype none
interface wbc_link_if;
  logic [15:0] frame_word;
  logic frame_toggle;
  logic [7:0] reply_byte;
  modport link (output frame_word, output frame_toggle, input reply_byte);
  modport core (input frame_word, input frame_toggle, output reply_byte);
endinterface : wbc_link_if
`default_nettype wire

/* rtl/wbc_spi_link.sv */
// wbc_spi_link: spi slave shift logic clocked by the host's serial clock
// assumes mode 0 timing, lsb first, sck idle while spi_cs_n is high
`timescale 1ns/100ps
`default_nettype none
module wbc_spi_link (
  // serial link from the host
  input wire logic spi_sck,
  input wire logic spi_cs_n,
  input wire logic spi_mosi,
  output logic spi_miso,
  // clears the event word and toggle only
  input wire logic reset,
  // words to and from the core
  wbc_link_if.link lnk
);
  import wbc_pkg::*;

  typedef struct packed {
    logic [3:0] bit_cnt;
    logic [14:0] shift;
  } wbc_rx_type;

  typedef struct packed {
    logic [15:0] word;
    logic toggle;
  } wbc_ev_type;

  wbc_rx_type rx_q;
  wbc_rx_type rx_d;
  wbc_ev_type ev_q;
  logic miso_q;
  logic [15:0] reply_word;

  // shift in lsb first; a whole frame lands after the sixteenth edge
  always_comb begin
    rx_d = rx_q;
    rx_d.bit_cnt = rx_q.bit_cnt + 4'h1;
    rx_d.shift = {spi_mosi, rx_q.shift[14:1]};
  end

  // the frame select ends the frame, since sck stops outside frames
  always_ff @(posedge spi_sck or posedge spi_cs_n) begin
    if (spi_cs_n) begin
      rx_q <= '0;
    end else begin
      rx_q <= rx_d;
    end
  end

  // toggle marks a new word; the word holds until the next full frame
  always_ff @(posedge spi_sck or posedge reset) begin
    if (reset) begin
      ev_q <= '0;
    end else if (rx_q.bit_cnt == 4'(WBC_FRAME_BITS - 1)) begin
      ev_q.word <= {spi_mosi, rx_q.shift};
      ev_q.toggle <= ~ev_q.toggle;
    end
  end

  // reply byte is quasi-static: the core only changes it right after a frame
  assign reply_word = {lnk.reply_byte, 8'h00};

  // next bit goes out on the falling edge, ahead of the host's sample
  always_ff @(negedge spi_sck or posedge spi_cs_n) begin
    if (spi_cs_n) begin
      miso_q <= 1'b0;
    end else begin
      miso_q <= reply_word[rx_q.bit_cnt];
    end
  end

  assign lnk.frame_word = ev_q.word;
  assign lnk.frame_toggle = ev_q.toggle;
  assign spi_miso = miso_q;
endmodule : wbc_spi_link
`default_nettype wire

/* dv/wbc_ctrl_regs_props.sv */
// wbc_ctrl_regs_props: port level checks of the control register block
// assumes it is bound into wbc_ctrl_regs and sees only its ports
`timescale 1ns/100ps
`default_nettype none
module wbc_ctrl_regs_props (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // events and levels
  input wire logic soft_reset,
  input wire logic restart,
  input wire wbc_pkg::wbc_chip_mode_type chip_mode,
  input wire logic boost_default_sel,
  // register contents and decoded settings
  input wire logic [7:0] watchdog_control,
  input wire logic [7:0] bus_control_one,
  input wire logic [7:0] bus_control_two,
  input wire logic [2:0] wdog_period_sel,
  input wire logic [9:0] wdog_period_ms,
  input wire logic wdog_active,
  input wire logic lin_flash_mode,
  input wire logic lin_slope_ctrl_on,
  input wire logic [1:0] can_mode_op,
  input wire logic [3:0][1:0] lin_mode_op,
  input wire logic boost_target_10v,
  // single bit fields and the pin enable
  input wire logic spi_cs_n,
  input wire logic spi_miso_oe,
  input wire logic wdog_stop_disable,
  input wire logic wdog_window_select,
  input wire logic wdog_start_on_bus_wake,
  input wire logic wdog_reset_limit,
  input wire logic lin_slow_slope_sel,
  input wire logic lin_tx_timeout_enable,
  input wire logic boost_high_level_sel
);
  import wbc_pkg::*;
  logic low_q;
  logic stop_q;
  logic boost_q;
  // operated outputs lag the mode inputs by one edge
  always_ff @(posedge clk) begin
    low_q <= (chip_mode == WBC_CHIP_STOP) || (chip_mode == WBC_CHIP_SLEEP);
    stop_q <= chip_mode == WBC_CHIP_STOP;
    boost_q <= boost_default_sel;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  restart_wdog_a: assert property (restart && !soft_reset |=>
    (watchdog_control & 8'h67) == 8'h04 && (watchdog_control &
    WBC_WD_KEEP_MASK) == ($past(watchdog_control) & WBC_WD_KEEP_MASK))
    else $error("restart left watchdog_control wrong");
  restart_bus_a: assert property (restart && !soft_reset |=>
    bus_control_two == ($past(bus_control_two) & WBC_B2_KEEP_MASK))
    else $error("restart left bus_control_two wrong");
  soft_load_a: assert property (soft_reset |=> watchdog_control ==
    WBC_WD_RESET && bus_control_one == WBC_B1_RESET &&
    bus_control_two == WBC_B2_RESET)
    else $error("soft reset values wrong");
  reserved_zero_a: assert property (bus_control_one[2] == 1'h0 &&
    bus_control_two[2] == 1'h0) else $error("reserved bit set");
  period_code_a: assert property (wdog_period_sel <= WBC_WD_CODE_LAST &&
    wdog_period_sel == watchdog_control[2:0])
    else $error("period code out of range");
  period_ms_a: assert property (wdog_period_ms ==
    WBC_WD_PERIOD_MS[wdog_period_sel]) else $error("period value wrong");
  stop_wdog_a: assert property (wdog_active ==
    !(stop_q && watchdog_control[6])) else $error("watchdog activity wrong");
  flash_slope_a: assert property (lin_flash_mode == bus_control_one[7] &&
    lin_slope_ctrl_on == !lin_flash_mode) else $error("slope control wrong");
  can_op_a: assert property (can_mode_op == ((low_q &&
    bus_control_one[1:0] == 2'h3) ? 2'h1 : bus_control_one[1:0]))
    else $error("can mode as operated wrong");
  lin_op_a: assert property (lin_mode_op[0] == ((low_q &&
    bus_control_one[4:3] == 2'h3) ? 2'h1 : bus_control_one[4:3]))
    else $error("lin mode as operated wrong");
  boost_sel_a: assert property (boost_target_10v ==
    (boost_q && bus_control_two[5])) else $error("boost target wrong");
  wd_fields_a: assert property ({wdog_stop_disable,
    wdog_window_select, wdog_start_on_bus_wake, wdog_reset_limit} ==
    watchdog_control[6:3]) else $error("watchdog field outputs wrong");
  lin_fields_a: assert property (lin_slow_slope_sel ==
    bus_control_one[6] && lin_tx_timeout_enable == bus_control_one[5] &&
    boost_high_level_sel == bus_control_two[5])
    else $error("lin or boost field outputs wrong");
  miso_enable_a: assert property (spi_miso_oe == !spi_cs_n)
    else $error("miso enable wrong");
endmodule : wbc_ctrl_regs_props
bind wbc_ctrl_regs wbc_ctrl_regs_props props (.clk(clk), .reset(reset),
  .soft_reset(soft_reset), .restart(restart), .chip_mode(chip_mode),
  .boost_default_sel(boost_default_sel), .watchdog_control(watchdog_control),
  .bus_control_one(bus_control_one), .bus_control_two(bus_control_two),
  .wdog_period_sel(wdog_period_sel), .wdog_period_ms(wdog_period_ms),
  .wdog_active(wdog_active), .lin_flash_mode(lin_flash_mode),
  .lin_slope_ctrl_on(lin_slope_ctrl_on), .can_mode_op(can_mode_op),
  .lin_mode_op(lin_mode_op), .boost_target_10v(boost_target_10v),
  .spi_cs_n(spi_cs_n), .spi_miso_oe(spi_miso_oe),
  .wdog_stop_disable(wdog_stop_disable),
  .wdog_window_select(wdog_window_select),
  .wdog_start_on_bus_wake(wdog_start_on_bus_wake),
  .wdog_reset_limit(wdog_reset_limit),
  .lin_slow_slope_sel(lin_slow_slope_sel),
  .lin_tx_timeout_enable(lin_tx_timeout_enable),
  .boost_high_level_sel(boost_high_level_sel));
`default_nettype wire

/* dv/wbc_host_model.sv */
// wbc_host_model: spi host sending one 16-bit frame per call of frame
// assumes mode 0, lsb first; serial clock of 32 ns runs only in frames
`timescale 1ns/100ps
`default_nettype none
module wbc_host_model (
  // serial link
  output logic spi_sck,
  output logic spi_cs_n,
  output logic spi_mosi,
  input wire logic spi_miso
);
  initial begin
    spi_sck = 1'h0;
    spi_mosi = 1'h0;
    // a late rise gives the link's select-driven reset a real edge
    #1 spi_cs_n = 1'h1;
  end
  // address, write flag, then data byte, all lsb first
  task automatic frame(input logic [15:0] w, output logic [15:0] r);
    #7.3 spi_cs_n = 1'h0;
    for (int i = 0; i < 16; i++) begin
      spi_mosi = w[i];
      #16 spi_sck = 1'h1;
      r[i] = spi_miso;
      #16 spi_sck = 1'h0;
    end
    #16 spi_cs_n = 1'h1;
    spi_mosi = ~spi_mosi; // released line must not look like held data
    #500; // gap lets the reply cross before the next frame
  endtask : frame
endmodule : wbc_host_model
`default_nettype wire

/* dv/testbench.sv */
// testbench: drives wbc_ctrl_regs over spi and its side inputs
// assumes the host model owns the serial pins; clk inputs move at negedge
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import wbc_pkg::*;
  logic clk = 1'h0, reset = 1'h0, soft_reset = 1'h0, restart = 1'h0;
  wbc_chip_mode_type chip_mode = WBC_CHIP_NORMAL;
  logic spi_sck, spi_cs_n, spi_mosi, spi_miso, spi_fail;
  logic hw_wdog_load = 1'h0, hw_bus1_load = 1'h0, hw_bus2_load = 1'h0;
  logic [7:0] hw_wdog_value = 8'h00, hw_bus1_value = 8'h00;
  logic [7:0] hw_bus2_value = 8'h00, watchdog_control, bus_control_one;
  logic [7:0] bus_control_two, pend = 8'h00, wd, b1, b2, d, exp_q[$];
  logic spi_fail_clear = 1'h0, boost_default_sel = 1'h0, armed = 1'h0;
  logic [1:0] can_mode_op;
  logic [3:0][1:0] lin_mode_op;
  logic [15:0] seen;
  int seed = 79266, miscompares = 0, comparisons = 0;
  event got;
  always #25 clk = ~clk;
  wbc_host_model host (.spi_sck(spi_sck), .spi_cs_n(spi_cs_n),
    .spi_mosi(spi_mosi), .spi_miso(spi_miso));
  wbc_ctrl_regs dut (.clk(clk), .reset(reset), .soft_reset(soft_reset),
    .restart(restart), .chip_mode(chip_mode), .spi_sck(spi_sck),
    .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi), .spi_miso(spi_miso),
    .spi_miso_oe(), .hw_wdog_load(hw_wdog_load), .hw_wdog_value(hw_wdog_value),
    .hw_bus1_load(hw_bus1_load), .hw_bus1_value(hw_bus1_value),
    .hw_bus2_load(hw_bus2_load), .hw_bus2_value(hw_bus2_value),
    .spi_fail_clear(spi_fail_clear), .spi_fail(spi_fail),
    .boost_default_sel(boost_default_sel), .watchdog_control(watchdog_control),
    .bus_control_one(bus_control_one), .bus_control_two(bus_control_two),
    .wdog_stop_disable(), .wdog_window_select(), .wdog_start_on_bus_wake(),
    .wdog_reset_limit(), .wdog_period_sel(), .wdog_period_ms(),
    .wdog_active(), .lin_flash_mode(), .lin_slope_ctrl_on(),
    .lin_slow_slope_sel(), .lin_tx_timeout_enable(), .can_mode_op(can_mode_op),
    .lin_mode_op(lin_mode_op), .boost_high_level_sel(), .boost_target_10v());
  task automatic check(input logic [7:0] s, input logic [7:0] e);
    comparisons++;
    if (s !== e) begin
      miscompares++;
      $display("mismatch at %0t seen %h expected %h", $time, s, e);
    end
  endtask : check
  // each reply carries the previous frame's register, low byte zero
  always @(got) begin
    check(seen[15:8], exp_q.pop_front());
    check(seen[7:0], 8'h00);
  end
  task automatic xfer(input logic [6:0] a, input logic w, input logic [7:0] v,
    input logic [7:0] e);
    logic [15:0] r;
    if (armed) exp_q.push_back(pend);
    host.frame({v, w, a}, r);
    seen = r;
    if (armed) ->got;
    pend = e;
    armed = 1'h1;
  endtask : xfer
  task automatic rd(input logic [6:0] a, input logic [7:0] e);
    xfer(a, 1'h0, 8'($random(seed)), e);
  endtask : rd
  task automatic regs_now;
    check(watchdog_control, wd);
    check(bus_control_one, b1);
    check(bus_control_two, b2);
  endtask : regs_now
  task automatic print_verdict;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : print_verdict
  // watchdog: the full run needs well under 100 us
  initial begin
    #400_000;
    miscompares++;
    print_verdict();
  end
  initial begin
    // a late rise gives the link's asynchronous reset a real edge
    #1 reset = 1'h1;
    repeat (3) @(negedge clk);
    reset = 1'h0;
    wd = WBC_WD_RESET;
    b1 = WBC_B1_RESET;
    b2 = WBC_B2_RESET;
    regs_now();
    rd(WBC_ADDR_WDOG, wd);
    rd(WBC_ADDR_BUS1, b1);
    rd(WBC_ADDR_BUS2, b2);
    xfer(7'h10, 1'h1, 8'hA5, 8'h00);
    $display("test reset_and_unmapped done");
    // random bus writes; the reserved bit never sticks
    for (int i = 0; i < 6; i++) begin
      d = 8'($random(seed));
      b1 = d & WBC_BUS_WR_MASK;
      xfer(WBC_ADDR_BUS1, 1'h1, d, b1);
      d = 8'($random(seed));
      b2 = d & WBC_BUS_WR_MASK;
      xfer(WBC_ADDR_BUS2, 1'h1, d, b2);
      @(negedge clk) boost_default_sel = d[0];
    end
    $display("test bus_writes done");
    // every period code with even parity, then an odd parity write
    for (int c = 0; c < 8; c++) begin
      d = {1'h0, 4'($random(seed)), 3'(c)};
      d[7] = ^d[6:0];
      wd = (c < 6) ? d : {d[7:3], wd[2:0]};
      xfer(WBC_ADDR_WDOG, 1'h1, d, wd);
    end
    xfer(WBC_ADDR_WDOG, 1'h1, 8'h15, wd);
    @(negedge clk);
    check({7'h00, spi_fail}, 8'h01);
    regs_now();
    spi_fail_clear = 1'h1;
    @(negedge clk) spi_fail_clear = 1'h0;
    @(negedge clk) check({7'h00, spi_fail}, 8'h00);
    $display("test watchdog_writes done");
    // hardware loads touch only hardware owned bits
    // bit 6 forced so that stop mode later runs with the watchdog off
    hw_wdog_value = 8'($random(seed)) | 8'h40;
    hw_bus1_value = 8'($random(seed));
    hw_bus2_value = 8'($random(seed));
    {hw_wdog_load, hw_bus1_load, hw_bus2_load} = 3'h7;
    @(negedge clk) {hw_wdog_load, hw_bus1_load, hw_bus2_load} = 3'h0;
    d = (wd & ~WBC_WD_HW_MASK) | (hw_wdog_value & WBC_WD_HW_MASK);
    wd = (hw_wdog_value[2:0] > 3'h5) ? {d[7:3], wd[2:0]} : d;
    b1 = (b1 & ~WBC_B1_HW_MASK) | (hw_bus1_value & WBC_B1_HW_MASK);
    b2 = (b2 & ~WBC_B2_HW_MASK) | (hw_bus2_value & WBC_B2_HW_MASK);
    regs_now();
    $display("test hardware_loads done");
    // stored normal runs as wake capable in stop and sleep
    xfer(WBC_ADDR_BUS2, 1'h1, 8'hC3, 8'hC3);
    for (int p = 1; p < 4; p++) begin
      b1 = 8'hD8 | 8'(p);
      xfer(WBC_ADDR_BUS1, 1'h1, b1, b1);
      for (int m = 0; m < 4; m++) begin
        if (m == 1 && p != 1) continue;
        @(negedge clk) chip_mode = wbc_chip_mode_type'(m);
        repeat (2) @(negedge clk);
        d = (m == 1 || m == 2) ? 8'h45 : 8'hCF;
        check(lin_mode_op, d);
        d = (p == 3 && d == 8'h45) ? 8'h01 : 8'(p);
        check({6'h00, can_mode_op}, d);
      end
      check(bus_control_one, b1);
    end
    $display("test operated_modes done");
    // restart keeps some bits and loads others
    b2 = 8'hE3;
    xfer(WBC_ADDR_BUS2, 1'h1, b2, b2);
    wd = 8'hED;
    xfer(WBC_ADDR_WDOG, 1'h1, wd, wd);
    @(negedge clk) restart = 1'h1;
    @(negedge clk) restart = 1'h0;
    wd = (wd & WBC_WD_KEEP_MASK) | 8'h04;
    b2 = b2 & WBC_B2_KEEP_MASK;
    regs_now();
    rd(WBC_ADDR_WDOG, wd);
    $display("test restart done");
    @(negedge clk) soft_reset = 1'h1;
    @(negedge clk) soft_reset = 1'h0;
    wd = WBC_WD_RESET;
    b1 = WBC_B1_RESET;
    b2 = WBC_B2_RESET;
    regs_now();
    rd(WBC_ADDR_BUS2, b2);
    rd(7'h7F, 8'h00);
    rd(WBC_ADDR_BUS1, b1);
    $display("test soft_reset done");
    print_verdict();
  end
endmodule : testbench
`default_nettype wire
